// [logic/sar_defs.svh]
// constants for the conversion control block: register map, fields,
// reset values and timing counts
// assumes byte addressing on a 32-bit APB bus
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH

`define SAR_CODE_W        16
`define SAR_MSB_IDX       4'hF
`define SAR_MIDSCALE      16'h8000
`define SAR_ACQ_CYCLES    16
`define SAR_APB_AW        8

`define SAR_CTRL_OFS      8'h00
`define SAR_ACQ_OFS       8'h04
`define SAR_STATUS_OFS    8'h08
`define SAR_RESULT_OFS    8'h0C

`define SAR_CTRL_RUN_BIT  0
`define SAR_CTRL_RST      1'b1
`define SAR_ST_BUSY_BIT   0
`define SAR_ST_WAIT_BIT   1
`define SAR_ST_REF_BIT    2
`define SAR_ST_BUF_BIT    3
`define SAR_ST_SLEEP_BIT  4

`endif

// [logic/sar_pkg.sv]
// types shared by the conversion control block and its coder
// assumes sar_defs.svh is on the include path
`include "sar_defs.svh"

package sar_pkg;
  typedef logic [`SAR_CODE_W-1:0] code_t;
  typedef logic [3:0]             bit_idx_t;
  typedef enum logic [1:0] {
    ST_ACQUIRE,
    ST_WAIT_EDGE,
    ST_CONVERT,
    ST_FINISH
  } conv_state_e;
endpackage

// [logic/code_fmt_if.sv]
// carrier between the search engine and the output coder
// assumes both ends sit in the same clock domain
`timescale 1ns/10ps
`default_nettype none

interface code_fmt_if;
  import sar_pkg::*;
  code_t raw;
  logic  binary_sel;
  logic  over_range;
  logic  under_range;
  code_t code;
  modport engine (output raw, binary_sel, over_range, under_range,
                  input code);
  modport coder  (input raw, binary_sel, over_range, under_range,
                  output code);
endinterface

`default_nettype wire

// [logic/result_coder.sv]
// output coder: saturation and binary / two's complement format
// assumes inputs stay stable for the cycle the result is latched
`timescale 1ns/10ps
`default_nettype none

module result_coder (
  code_fmt_if.coder f
);
  import sar_pkg::*;

  code_t sat;

  // clamp first, then the format flip, so both formats share one clamp
  assign sat    = f.over_range  ? {`SAR_CODE_W{1'b1}} :
                  f.under_range ? {`SAR_CODE_W{1'b0}} :
                  f.raw;
  // two's complement is only the top bit inverted
  assign f.code = f.binary_sel ? sat : (sat ^ `SAR_MIDSCALE);
endmodule

`default_nettype wire

// [logic/sar_conversion_control.sv]
// conversion control of a 16-bit successive-approximation converter
// assumes the comparator decision is valid one cycle after dac_code
// changes, and pins are synchronous to mclk
//
// Function
// - convert_start_n high at acquisition end: wait for its falling edge.
// - convert_start_n low at acquisition end: hold and convert at once.
// - binary search over 16 weights, most significant first, halving.
// - form final code, then drop busy to end conversion.
// - coding_select picks straight binary or two's complement.
// - at or above full scale minus one step saturates to maximum code.
// - zero or underrange saturates to minimum code.
// - reference_powerdown high turns on-chip reference off; low keeps it.
// - ref_buffer_powerdown low selects buffer; high switches it off.
// - busy rises at start, stays high until result latched.
// - device_reset high resets and aborts any running conversion; in ST_FINISH the result still latches.
// - device_sleep blocks new conversions after the current one ends.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "sar_defs.svh"

module sar_conversion_control #(
  parameter int ACQ_CYCLES = `SAR_ACQ_CYCLES
) (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`SAR_APB_AW-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // host pins
  input  wire logic                   convert_start_n,
  input  wire logic                   coding_select,
  input  wire logic                   reference_powerdown,
  input  wire logic                   ref_buffer_powerdown,
  input  wire logic                   device_sleep,
  input  wire logic                   device_reset,
  // analog front end
  input  wire logic                   comp_in,
  input  wire logic                   over_range,
  input  wire logic                   under_range,
  output sar_pkg::code_t              dac_code,
  output logic                        hold,
  output logic                        ref_enable,
  output logic                        buffer_enable,
  // conversion status
  output logic                        busy,
  output sar_pkg::code_t              result
);
  import sar_pkg::*;

  if (ACQ_CYCLES < 1 || ACQ_CYCLES > 65535) begin : g_bad_acq
    $error("ACQ_CYCLES must lie in 1..65535");
  end

  localparam logic [15:0] ACQ_RST = 16'(ACQ_CYCLES);

  function automatic code_t trial_bit(input bit_idx_t i);
    trial_bit = code_t'(1) << i;
  endfunction

  conv_state_e st_q, st_d;
  bit_idx_t    idx_q, idx_d;
  code_t       dac_q, dac_d, raw_q, raw_d, res_q, res_d, kept;
  logic [15:0] acq_cnt_q, acq_cnt_d, acq_len_q;
  logic        busy_q, busy_d, hold_q, hold_d, cs_prev_q;
  logic        run_en_q, ref_on_q, buf_on_q;
  logic        fmt_q, ovr_q, und_q, fmt_d, ovr_d, und_d;
  logic [31:0] rdata_q;
  logic        ready_q, err_q;

  code_fmt_if fmt_bus ();
  assign fmt_bus.raw         = raw_q;
  assign fmt_bus.binary_sel  = fmt_q;
  assign fmt_bus.over_range  = ovr_q;
  assign fmt_bus.under_range = und_q;

  result_coder u_coder (
    .f (fmt_bus)
  );

  // pin decode and search helpers
  wire acq_done  = ({1'b0, acq_cnt_q} + 17'h00001) >= {1'b0, acq_len_q};
  wire can_start = run_en_q & ~device_sleep;
  wire start_fall = cs_prev_q & ~convert_start_n;
  assign kept = comp_in ? dac_q : (dac_q & ~trial_bit(idx_q));

  always_comb begin
    st_d      = st_q;
    idx_d     = idx_q;
    dac_d     = dac_q;
    raw_d     = raw_q;
    res_d     = res_q;
    acq_cnt_d = acq_cnt_q;
    busy_d    = busy_q;
    hold_d    = hold_q;
    fmt_d     = fmt_q;
    ovr_d     = ovr_q;
    und_d     = und_q;
    case (st_q)
      ST_ACQUIRE: begin
        if (!acq_done) begin
          acq_cnt_d = acq_cnt_q + 16'h0001;
        end else if (can_start && !convert_start_n) begin
          st_d   = ST_CONVERT;
          busy_d = 1'b1;
          hold_d = 1'b1;
          idx_d  = `SAR_MSB_IDX;
          dac_d  = trial_bit(`SAR_MSB_IDX);
        end else if (can_start) begin
          st_d = ST_WAIT_EDGE;
        end
      end
      ST_WAIT_EDGE: begin
        // sleep or disable while waiting drops back to acquisition
        if (!can_start) begin
          st_d = ST_ACQUIRE;
        end else if (start_fall) begin
          st_d   = ST_CONVERT;
          busy_d = 1'b1;
          hold_d = 1'b1;
          idx_d  = `SAR_MSB_IDX;
          dac_d  = trial_bit(`SAR_MSB_IDX);
        end
      end
      ST_CONVERT: begin
        if (idx_q == 4'h0) begin
          raw_d = kept;
          // format and range captured once; host keeps pins steady
          fmt_d = coding_select;
          ovr_d = over_range;
          und_d = under_range;
          st_d  = ST_FINISH;
        end else begin
          idx_d = idx_q - 4'h1;
          dac_d = kept | trial_bit(idx_q - 4'h1);
        end
      end
      ST_FINISH: begin
        res_d     = fmt_bus.code;
        busy_d    = 1'b0;
        hold_d    = 1'b0;
        acq_cnt_d = 16'h0000;
        st_d      = ST_ACQUIRE;
      end
      default: begin
        st_d = ST_ACQUIRE;
      end
    endcase
    if (device_reset) begin
      st_d      = ST_ACQUIRE;
      busy_d    = 1'b0;
      hold_d    = 1'b0;
      acq_cnt_d = 16'h0000;
      dac_d     = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q      <= ST_ACQUIRE;
      idx_q     <= 4'h0;
      dac_q     <= '0;
      raw_q     <= '0;
      res_q     <= '0;
      acq_cnt_q <= 16'h0000;
      busy_q    <= 1'b0;
      hold_q    <= 1'b0;
      fmt_q     <= 1'b1;
      ovr_q     <= 1'b0;
      und_q     <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      st_q      <= st_d;
      idx_q     <= idx_d;
      dac_q     <= dac_d;
      raw_q     <= raw_d;
      res_q     <= res_d;
      acq_cnt_q <= acq_cnt_d;
      busy_q    <= busy_d;
      hold_q    <= hold_d;
      fmt_q     <= fmt_d;
      ovr_q     <= ovr_d;
      und_q     <= und_d;
      cs_prev_q <= convert_start_n;
    end
  end

  // static reference pins, registered so outputs come from flops
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ref_on_q <= 1'b0;
      buf_on_q <= 1'b0;
    end else begin
      ref_on_q <= ~reference_powerdown;
      buf_on_q <= ~ref_buffer_powerdown;
    end
  end

  // apb decode: answer in the first access cycle, no wait states
  wire setup    = psel & ~penable;
  wire wr_acc   = psel & penable & pwrite & ready_q;
  wire hit_ctrl = paddr == `SAR_CTRL_OFS;
  wire hit_acq  = paddr == `SAR_ACQ_OFS;
  wire hit_stat = paddr == `SAR_STATUS_OFS;
  wire hit_res  = paddr == `SAR_RESULT_OFS;
  wire hit_any  = hit_ctrl | hit_acq | hit_stat | hit_res;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) rd_mux[`SAR_CTRL_RUN_BIT] = run_en_q;
    if (hit_acq)  rd_mux[15:0] = acq_len_q;
    if (hit_stat) begin
      rd_mux[`SAR_ST_BUSY_BIT]  = busy_q;
      rd_mux[`SAR_ST_WAIT_BIT]  = st_q == ST_WAIT_EDGE;
      rd_mux[`SAR_ST_REF_BIT]   = ref_on_q;
      rd_mux[`SAR_ST_BUF_BIT]   = buf_on_q;
      rd_mux[`SAR_ST_SLEEP_BIT] = device_sleep;
    end
    if (hit_res)  rd_mux[15:0] = res_q;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ready_q   <= 1'b0;
      err_q     <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      run_en_q  <= `SAR_CTRL_RST;
      acq_len_q <= ACQ_RST;
    end else begin
      ready_q <= setup;
      err_q   <= setup & ~hit_any;
      rdata_q <= setup ? rd_mux : 32'h0000_0000;
      if (wr_acc && hit_ctrl) run_en_q  <= pwdata[`SAR_CTRL_RUN_BIT];
      // zero is stored as written; acq_done then ends acquisition after one cycle, as for one
      if (wr_acc && hit_acq)  acq_len_q <= pwdata[15:0];
    end
  end

  assign prdata        = rdata_q;
  assign pready        = ready_q;
  assign pslverr       = err_q;
  assign dac_code      = dac_q;
  assign hold          = hold_q;
  assign ref_enable    = ref_on_q;
  assign buffer_enable = buf_on_q;
  assign busy          = busy_q;
  assign result        = res_q;
endmodule

`default_nettype wire

// [bench/host_model.sv]
// host model: conversion start and strap pins
// the bench calls its tasks between conversions and also mid conversion, to release start and set sleep
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock
  input  wire logic mclk,
  // host pins
  output logic      convert_start_n,
  output logic      coding_select,
  output logic      reference_powerdown,
  output logic      ref_buffer_powerdown,
  output logic      device_sleep
);
  initial begin
    convert_start_n = 1'b1;
    coding_select = 1'b1;
    {reference_powerdown, ref_buffer_powerdown, device_sleep} = 3'h0;
  end
  // a low held past acquisition end starts at once
  task automatic drive(input logic v);
    @(posedge mclk) convert_start_n <= v;
  endtask
  // straps move while idle, except sleep, which the bench sets once mid conversion
  task automatic straps(input logic [3:0] v);
    @(posedge mclk) {coding_select, reference_powerdown,
      ref_buffer_powerdown, device_sleep} <= v;
  endtask
endmodule
`default_nettype wire

// [bench/sar_conversion_control_monitor.sv]
// assertions on the conversion control ports
// assumes one clock domain; bound to the top module below
`timescale 1ns/10ps
`default_nettype none
module sar_conversion_control_monitor (
  // clock and reset
  input wire logic           mclk,
  input wire logic           rstn,
  // pins
  input wire logic           convert_start_n,
  input wire logic           coding_select,
  input wire logic           reference_powerdown,
  input wire logic           ref_buffer_powerdown,
  input wire logic           device_reset,
  input wire logic           over_range,
  input wire logic           under_range,
  // outputs
  input wire sar_pkg::code_t dac_code,
  input wire logic           ref_enable,
  input wire logic           buffer_enable,
  input wire logic           hold,
  input wire logic           busy,
  input wire sar_pkg::code_t result
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn || device_reset);
  // end of a finished conversion, not an abort
  sequence done;
    $fell(busy) && !$past(device_reset);
  endsequence
  a_busy_span: assert property ($rose(busy) |-> ##16 busy ##1 !busy)
    else $error("busy length wrong");
  a_msb_first: assert property ($rose(busy) |-> dac_code == 16'h8000)
    else $error("first trial not midscale");
  a_hold_track: assert property (hold == busy)
    else $error("hold differs from busy");
  a_start_low: assert property ($rose(busy) |->
    !$past(convert_start_n) || !$past(convert_start_n, 2))
    else $error("start without low request");
  a_ref_track: assert property ($past(rstn) |->
    ref_enable == !$past(reference_powerdown))
    else $error("reference enable wrong");
  a_buf_track: assert property ($past(rstn) |->
    buffer_enable == !$past(ref_buffer_powerdown))
    else $error("buffer enable wrong");
  a_abort_now: assert property (disable iff (!rstn)
    device_reset |=> !busy)
    else $error("abort did not stop");
  a_sat_high: assert property (done ##0 $past(over_range, 2) |->
    result == ($past(coding_select, 2) ? 16'hFFFF : 16'h7FFF))
    else $error("overrange code wrong");
  a_sat_low: assert property (done ##0 ($past(under_range, 2) &&
    !$past(over_range, 2)) |->
    result == ($past(coding_select, 2) ? 16'h0000 : 16'h8000))
    else $error("underrange code wrong");
  c_done: cover property (done);
  c_abort: cover property (disable iff (!rstn) busy && device_reset);
  c_over: cover property (done ##0 $past(over_range, 2));
endmodule
bind sar_conversion_control sar_conversion_control_monitor mon (.mclk,
  .rstn, .convert_start_n, .coding_select, .reference_powerdown,
  .ref_buffer_powerdown, .device_reset, .over_range, .under_range,
  .dac_code, .ref_enable, .buffer_enable, .hold, .busy, .result);
`default_nettype wire

// [bench/sar_conversion_control_tb.sv]
// self-checking bench for the conversion control block
// assumes host model and monitor compiled first
`timescale 1ns/10ps
`default_nettype none
module sar_conversion_control_tb;
  import sar_pkg::*;
  localparam int ACQ = 4;
  logic mclk, rstn, psel, penable, pwrite, comp_in, over_range, bz;
  logic under_range, device_reset, pready, pslverr, hold, busy, err;
  logic ref_enable, buffer_enable, convert_start_n, coding_select;
  logic reference_powerdown, ref_buffer_powerdown, device_sleep, ov, un;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  code_t dac_code, result, vin, e, last;
  code_t q[$];
  int checks = 0;
  int miscompares = 0;
  // ideal comparator on the trial code
  assign comp_in = vin >= dac_code;
  host_model host (.mclk, .convert_start_n, .coding_select,
    .reference_powerdown, .ref_buffer_powerdown, .device_sleep);
  sar_conversion_control #(.ACQ_CYCLES(ACQ)) dut (.mclk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .convert_start_n, .coding_select, .reference_powerdown,
    .ref_buffer_powerdown, .device_sleep, .device_reset, .comp_in,
    .over_range, .under_range, .dac_code, .hold, .ref_enable,
    .buffer_enable, .busy, .result);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, s, x);
    end
  endtask
  task automatic tmo();
    miscompares++;
    report_and_stop();
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk) penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) tmo();
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic wait_busy(input logic v);
    int n;
    for (n = 0; n < 200 && busy !== v; n++) @(posedge mclk);
    if (n == 200) tmo();
  endtask
  // results are compared in order of request
  always @(negedge mclk) begin
    if (bz && !busy && q.size() > 0) check(result, q.pop_front());
    bz = busy;
  end
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    {rstn, psel, penable, pwrite, over_range, under_range} = 6'h00;
    {device_reset, paddr, pwdata, vin} = 57'h0;
    seed = 32'h8A15CC0F;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    seed = xs(seed);
    apb(1'b0, 8'h04, seed);
    check(rd, ACQ);
    // random upper bits must not reach the 16-bit count
    apb(1'b1, 8'h04, {seed[31:16], 16'h0002});
    apb(1'b0, 8'h04, seed);
    check(rd, 32'h2);
    // unmapped word, random direction and data: error, no effect
    apb(seed[8], {seed[7:4] | 4'h1, 4'h0}, seed);
    check({rd[30:0], err}, 32'h1);
    // codings, saturation, then two starts from one held low
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      ov = i inside {2, 3};
      un = i inside {4, 5};
      host.straps({i[0], seed[17:16], 1'b0});
      e = i == 0 ? 16'h8000 : seed[15:0];
      vin <= e;
      over_range <= ov;
      under_range <= un;
      if (ov) e = 16'hFFFF;
      if (un) e = 16'h0000;
      last = i[0] ? e : e ^ 16'h8000;
      q.push_back(last);
      if (i == 7) q.push_back(last);
      repeat (4) @(posedge mclk);
      check(busy, 1'b0);
      check(ref_enable, !seed[17]);
      check(buffer_enable, !seed[16]);
      host.drive(1'b0);
      wait_busy(1'b1);
      if (i < 7) host.drive(1'b1);
      // sleep mid conversion: this one must still finish and report
      if (i == 3) host.straps({i[0], seed[17:16], 1'b1});
      wait_busy(1'b0);
      if (i == 7) begin
        wait_busy(1'b1);
        host.drive(1'b1);
        wait_busy(1'b0);
      end
    end
    host.straps(4'h9);
    host.drive(1'b0);
    repeat (30) @(posedge mclk);
    check(busy, 1'b0);
    host.drive(1'b1);
    host.straps(4'h8);
    host.drive(1'b0);
    wait_busy(1'b1);
    host.drive(1'b1);
    device_reset <= 1'b1;
    @(posedge mclk) device_reset <= 1'b0;
    @(negedge mclk) check(busy, 1'b0);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd, last);
    for (int k = 0; k < 4; k++) begin
      host.straps({1'b1, k[1:0], 1'b0});
      repeat (2) @(posedge mclk);
      check(ref_enable, !k[1]);
      check(buffer_enable, !k[0]);
    end
    check(q.size(), 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
